// >>> pm_i2c_checker.sv
// checker of the open-drain bus between the controller and target ends
// assumes it sees the interface nets, sampled on the controller clock
`timescale 1ns/10ps
module pm_i2c_checker (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // interface nets
  input wire logic ctrl_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // --------------------------------
  // bus tracking
  // --------------------------------
  logic       scl_r, sda_r, addr_r, ign_r, idle_r;
  logic [3:0] cnt_r;
  logic [7:0] sr_r;
  // line history; bits shifted in on each scl rise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      sr_r  <= 8'h00;
    end else begin
      scl_r <= scl;
      sda_r <= sda;
      if (scl && !scl_r) sr_r <= {sr_r[6:0], sda};
    end
  end
  // bit slot, address phase, and windows where the target must stay off the bus
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r  <= 4'h0;
      addr_r <= 1'b0;
      ign_r  <= 1'b0;
      idle_r <= 1'b1;
    end else if (scl && scl_r && sda_r && !sda) begin  // start
      cnt_r  <= 4'h0;
      addr_r <= 1'b1;
      ign_r  <= 1'b0;
      idle_r <= 1'b0;
    end else if (scl && scl_r && !sda_r && sda) begin  // stop
      addr_r <= 1'b0;
      ign_r  <= 1'b0;
      idle_r <= 1'b1;
    end else if (scl && !scl_r) begin
      cnt_r  <= (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
      addr_r <= addr_r && (cnt_r != 4'h8);
      ign_r  <= ign_r || (cnt_r == 4'h8 && sda);  // nack ends the transfer
    end
  end
  // --------------------------------
  // assertions
  // --------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ninth scl rise after a start: the address acknowledge slot
  sequence ack_slot_s;
    scl && !scl_r && cnt_r == 4'h8 && addr_r;
  endsequence
  open_drain_a: assert property (dev_sda_o == 1'b0)
    else $error("target drives sda high");
  scl_free_a: assert property (!ctrl_scl_oe |-> scl)
    else $error("scl held low by the target");
  dev_stable_a: assert property (scl && scl_r |-> $stable(dev_sda_oe))
    else $error("target sda changed while scl high");
  addr_quiet_a: assert property (addr_r && cnt_r < 4'h8 |-> !dev_sda_oe)
    else $error("target drove sda in the address byte");
  nack_quiet_a: assert property (ign_r |-> !dev_sda_oe)
    else $error("target drove sda after a nack");
  stop_quiet_a: assert property (idle_r |-> !dev_sda_oe)
    else $error("target drove sda after a stop");
  hs_noack_a: assert property (ack_slot_s ##0 sr_r[7:3] == 5'h01 |-> sda)
    else $error("speed code acknowledged");
  foreign_noack_a: assert property (ack_slot_s ##0 (sr_r[7:5] != 3'h4 &&
    sr_r[7:1] != 7'h0C) |-> sda)
    else $error("foreign address acknowledged");
endmodule  // pm_i2c_checker

// >>> pm_i2c_controller.sv
// bus controller end: makes scl by division and runs one transfer per command
// assumes the target never stretches scl, so scl is not read back
`timescale 1ns/10ps
module pm_i2c_controller #(
  parameter int FS_QTR = pm_i2c_pkg::FS_QTR_CYC,
  parameter int HS_QTR = pm_i2c_pkg::HS_QTR_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // bus
  pm_i2c_if.controller     bus,
  // command
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_read,
  input  wire logic        cmd_hs,
  input  wire logic        cmd_stop,
  input  wire logic [6:0]  cmd_addr,
  input  wire logic [1:0]  cmd_nbytes,
  input  wire logic [23:0] cmd_wdata,
  // answer
  output logic             done,
  output logic             nack,
  output logic [23:0]      rdata,
  output logic             hs_active
);

  typedef enum logic [3:0] {
    C_IDLE  = 4'b0001,
    C_START = 4'b0010,
    C_BIT   = 4'b0100,
    C_STOP  = 4'b1000
  } ctrl_state_type;

  ctrl_state_type st_r;
  logic [7:0]  q_r;
  logic [1:0]  ph_r;
  logic [3:0]  bit_r;
  logic [1:0]  byte_r;
  logic [1:0]  nb_r;
  logic        rd_r;
  logic        hsc_r;
  logic        stop_r;
  logic        nak_r;
  logic [7:0]  cur_r;
  logic [23:0] dat_r;
  logic        sda_m_r;
  logic        sda_s_r;
  logic        scl_oe_r;
  logic        sda_oe_r;
  logic [7:0]  qlim;
  logic        tick;
  logic        txb;

  assign bus.ctrl_scl_o  = 1'b0;
  assign bus.ctrl_sda_o  = 1'b0;
  assign bus.ctrl_scl_oe = scl_oe_r;
  assign bus.ctrl_sda_oe = sda_oe_r;
  assign cmd_ready       = (st_r == C_IDLE);
  // the speed-entry code itself goes at the slow rate unless hs_active is already set
  assign qlim = hs_active ? 8'(HS_QTR - 1) : 8'(FS_QTR - 1);
  assign tick = (q_r == qlim);
  assign txb  = (byte_r == 2'h0) || !rd_r;

  // ------------------------------------------------------------
  // sda sampling and quarter-bit timebase
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      q_r     <= 8'h00;
      ph_r    <= 2'h0;
    end else begin
      sda_m_r <= bus.sda;
      sda_s_r <= sda_m_r;
      q_r     <= (tick || st_r == C_IDLE) ? 8'h00 : q_r + 8'h01;
      ph_r    <= (st_r == C_IDLE) ? 2'h0 : ph_r + 2'(tick);
    end
  end

  // ------------------------------------------------------------
  // transfer sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= C_IDLE;     bit_r <= 4'h0;   byte_r <= 2'h0;  nb_r <= 2'h0;
      rd_r <= 1'b0;       hsc_r <= 1'b0;   stop_r <= 1'b0;  nak_r <= 1'b0;
      cur_r <= 8'h00;     dat_r <= 24'h0;  scl_oe_r <= 1'b0; sda_oe_r <= 1'b0;
      done <= 1'b0;       nack <= 1'b0;    rdata <= 24'h0;  hs_active <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (st_r)
        C_IDLE: if (cmd_valid) begin
          st_r <= C_START;  rd_r <= cmd_read && !cmd_hs;  hsc_r <= cmd_hs;
          stop_r <= cmd_stop && !cmd_hs;  nb_r <= cmd_hs ? 2'h0 : cmd_nbytes;
          cur_r <= cmd_hs ? pm_i2c_pkg::HS_CODE : {cmd_addr, cmd_read};
          dat_r <= cmd_wdata;  nak_r <= 1'b0;  rdata <= 24'h0;
        end
        // works from idle and from a held bus (repeated start)
        C_START: if (tick) begin
          unique case (ph_r)
            2'h0: sda_oe_r <= 1'b0;
            2'h1: scl_oe_r <= 1'b0;
            2'h2: sda_oe_r <= 1'b1;
            2'h3: begin scl_oe_r <= 1'b1; st_r <= C_BIT; bit_r <= 4'h0; byte_r <= 2'h0; end
          endcase
        end
        C_BIT: if (tick) begin
          unique case (ph_r)
            2'h0: if (bit_r == pm_i2c_pkg::ACK_SLOT) sda_oe_r <= !txb && (byte_r != nb_r);
                  else sda_oe_r <= txb && !cur_r[7];
            2'h1: scl_oe_r <= 1'b0;
            2'h2: if (bit_r == pm_i2c_pkg::ACK_SLOT) nak_r <= txb && sda_s_r;
                  else if (txb) cur_r <= {cur_r[6:0], 1'b0};
                  else rdata <= {rdata[22:0], sda_s_r};
            2'h3: begin
              scl_oe_r <= 1'b1;
              bit_r    <= bit_r + 4'h1;
              if (bit_r == pm_i2c_pkg::ACK_SLOT) begin
                bit_r <= 4'h0;
                if (hsc_r) begin
                  hs_active <= 1'b1; st_r <= C_IDLE; done <= 1'b1;
                end else if (nak_r || byte_r == nb_r) begin
                  nack <= nak_r;
                  if (stop_r || nak_r) st_r <= C_STOP;
                  else begin st_r <= C_IDLE; done <= 1'b1; end
                end else begin
                  byte_r <= byte_r + 2'h1;
                  cur_r  <= dat_r[23:16];
                  dat_r  <= {dat_r[15:0], 8'h00};
                end
              end
            end
          endcase
        end
        C_STOP: if (tick) begin
          unique case (ph_r)
            2'h0: sda_oe_r <= 1'b1;
            2'h1: scl_oe_r <= 1'b0;
            2'h2: sda_oe_r <= 1'b0;
            2'h3: begin st_r <= C_IDLE; done <= 1'b1; hs_active <= 1'b0; end
          endcase
        end
      endcase
    end
  end

endmodule // pm_i2c_controller

// >>> pm_i2c_if.sv
// open-drain two-wire bus between the controller and the target port
// assumes pull-ups: a line is high unless some party enables a low drive
`timescale 1ns/10ps
interface pm_i2c_if;
  logic ctrl_scl_o;
  logic ctrl_scl_oe;
  logic ctrl_sda_o;
  logic ctrl_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // wired-and of all enabled drivers over the pull-up
  assign scl = !(ctrl_scl_oe && !ctrl_scl_o);
  assign sda = !((ctrl_sda_oe && !ctrl_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport target     (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport controller (input sda, output ctrl_scl_o, output ctrl_scl_oe,
                      output ctrl_sda_o, output ctrl_sda_oe);
endinterface

// >>> pm_i2c_pkg.sv
// power monitor two-wire port: shared offsets, codes, resets and timing
// assumes both ends and the bench compile this package first
package pm_i2c_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] REG_GENERAL_SETUP  = 8'h00;
  localparam logic [7:0] REG_CONV_SETUP     = 8'h01;
  localparam logic [7:0] REG_SHUNT_SCALING  = 8'h02;
  localparam logic [7:0] REG_SHUNT_RESULT   = 8'h04;
  localparam logic [7:0] REG_BUS_RESULT     = 8'h05;
  localparam logic [7:0] REG_TEMP_RESULT    = 8'h06;
  localparam logic [7:0] REG_CURRENT_RESULT = 8'h07;
  localparam logic [7:0] REG_POWER_RESULT   = 8'h08;
  localparam logic [7:0] REG_DIAG_FLAGS     = 8'h0B;
  localparam logic [7:0] REG_SHUNT_OVER     = 8'h0C;
  localparam logic [7:0] REG_SHUNT_UNDER    = 8'h0D;
  localparam logic [7:0] REG_BUS_OVER       = 8'h0E;
  localparam logic [7:0] REG_BUS_UNDER      = 8'h0F;
  localparam logic [7:0] REG_HEAT_LIMIT     = 8'h10;
  localparam logic [7:0] REG_POWER_CEILING  = 8'h11;
  localparam logic [7:0] REG_MAKER_CODE     = 8'h3E;
  localparam int         RW_DEPTH           = 18;

  // writable locations that live in the port's own storage
  function automatic logic rw_hit(input logic [7:0] p);
    return (p <= REG_SHUNT_SCALING) || (p >= REG_SHUNT_OVER && p <= REG_POWER_CEILING);
  endfunction

  // reset value of each writable location
  function automatic logic [15:0] rw_reset(input logic [4:0] i);
    unique case (i)
      5'h01:   return 16'hFB68;
      5'h0C:   return 16'h7FFF;
      5'h0D:   return 16'h8000;
      5'h0E:   return 16'h7FFF;
      5'h10:   return 16'hFFFF;
      5'h11:   return 16'h7FFF;
      default: return 16'h0000;
    endcase
  endfunction

  // ------------------------------------------------------------
  // address and byte codes
  // ------------------------------------------------------------
  localparam logic [2:0] ADDR_TOP    = 3'h4;
  localparam logic [6:0] ALERT_ADDR  = 7'h0C;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam logic [7:0] HS_CODE     = 8'h08;
  localparam logic [3:0] ACK_SLOT    = 4'h8;
  localparam logic [1:0] WORD_BYTES  = 2'h2;
  localparam logic [1:0] POWER_BYTES = 2'h3;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam logic [3:0] FILT_FS_CYC = 4'h3;  // link samples a level must hold
  localparam logic [3:0] FILT_HS_CYC = 4'h1;
  localparam int CLK_KHZ     = 250000;
  localparam int FS_RATE_KHZ = 400;
  localparam int HS_RATE_KHZ = 2940;
  localparam int FS_QTR_CYC  = (CLK_KHZ + 4 * FS_RATE_KHZ - 1) / (4 * FS_RATE_KHZ);
  localparam int HS_QTR_CYC  = (CLK_KHZ + 4 * HS_RATE_KHZ - 1) / (4 * HS_RATE_KHZ);

endpackage

// >>> pm_i2c_target.sv
// target end of the power monitor two-wire port, with its register storage
// assumes link_clk oversamples scl several times per bit; clk runs the registers
`timescale 1ns/10ps
module pm_i2c_target #(
  parameter logic [15:0] MAKER_CODE = 16'h5A5A  // arbitrary value
) (
  // clocks and reset
  input  wire logic        clk,
  input  wire logic        link_clk,
  input  wire logic        nrst,
  // bus
  pm_i2c_if.target         bus,
  // address straps, two-bit level codes
  input  wire logic [1:0]  addr_strap_high,
  input  wire logic [1:0]  addr_strap_low,
  // measurement side, clk domain
  input  wire logic [15:0] shunt_voltage_result,
  input  wire logic [15:0] bus_voltage_result,
  input  wire logic [15:0] die_temperature_result,
  input  wire logic [15:0] current_result,
  input  wire logic [23:0] power_result,
  input  wire logic [15:0] diagnostic_flags,
  input  wire logic        alert_pending,
  // register write notice and status, clk domain
  output logic             wr_stb,
  output logic [7:0]       wr_ptr,
  output logic [15:0]      wr_word,
  output logic             alert_served,
  output logic             fast_plus_speed
);

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_RX   = 5'b00010,
    S_ACK  = 5'b00100,
    S_TX   = 5'b01000,
    S_MACK = 5'b10000
  } tgt_state_type;

  // ------------------------------------------------------------
  // link domain: input sync and glitch filter
  // ------------------------------------------------------------
  logic [1:0]  raw_m_r;
  logic [1:0]  raw_s_r;
  logic [1:0]  filt_r;
  logic [1:0]  filt_q_r;
  logic [3:0]  strap_m_r;
  logic [3:0]  strap_s_r;
  logic        hs_r;
  logic [3:0]  flim;

  // two stages before anything reads a pin
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      raw_m_r   <= 2'h3;
      raw_s_r   <= 2'h3;
      strap_m_r <= 4'h0;
      strap_s_r <= 4'h0;
    end else begin
      raw_m_r   <= {bus.scl, bus.sda};
      raw_s_r   <= raw_m_r;
      strap_m_r <= {addr_strap_high, addr_strap_low};
      strap_s_r <= strap_m_r;
    end
  end

  assign flim = hs_r ? pm_i2c_pkg::FILT_HS_CYC : pm_i2c_pkg::FILT_FS_CYC;

  // a level must hold flim samples; shorter spikes never reach the engine
  for (genvar g = 0; g < 2; g++) begin : g_filt
    logic [3:0] cnt_r;
    always_ff @(posedge link_clk or negedge nrst) begin
      if (!nrst) begin
        cnt_r     <= 4'h0;
        filt_r[g] <= 1'b1;
      end else if (raw_s_r[g] == filt_r[g]) begin
        cnt_r <= 4'h0;
      end else if (cnt_r + 4'h1 >= flim) begin
        cnt_r     <= 4'h0;
        filt_r[g] <= raw_s_r[g];
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) filt_q_r <= 2'h3;
    else       filt_q_r <= filt_r;
  end

  logic scl_f;
  logic sda_f;
  logic st_cond;
  logic sp_cond;
  logic rise;
  logic fall;
  assign scl_f   = filt_r[1];
  assign sda_f   = filt_r[0];
  assign st_cond = scl_f && filt_q_r[1] && filt_q_r[0] && !sda_f;
  assign sp_cond = scl_f && filt_q_r[1] && !filt_q_r[0] && sda_f;
  assign rise    = scl_f && !filt_q_r[1];
  assign fall    = !scl_f && filt_q_r[1];

  // ------------------------------------------------------------
  // link domain: crossings in
  // ------------------------------------------------------------
  logic [2:0]  rd_ack_sync_r;
  logic [1:0]  alert_sync_r;
  logic [23:0] rd_hold_r;
  logic [23:0] rd_cap_r;
  logic        rd_ack_tgl_r;

  // hold word is stable whenever the ack toggle differs, so it may be caught
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      rd_ack_sync_r <= 3'h0;
      alert_sync_r  <= 2'h0;
      rd_cap_r      <= 24'h0;
    end else begin
      rd_ack_sync_r <= {rd_ack_sync_r[1:0], rd_ack_tgl_r};
      alert_sync_r  <= {alert_sync_r[0], alert_pending};
      if (rd_ack_sync_r[2] != rd_ack_sync_r[1]) rd_cap_r <= rd_hold_r;
    end
  end

  // ------------------------------------------------------------
  // link domain: byte engine
  // ------------------------------------------------------------
  tgt_state_type st_r;
  logic [7:0]  sh_r;
  logic [3:0]  cnt_r;
  logic [2:0]  byte_r;
  logic        rd_r;
  logic        ara_r;
  logic        cont_r;
  logic [6:0]  own_r;
  logic [7:0]  ptr_r;
  logic [7:0]  hi_r;
  logic [15:0] wdat_r;
  logic [23:0] txw_r;
  logic [1:0]  txn_r;
  logic        oe_r;
  logic        wr_tgl_r;
  logic        rd_tgl_r;
  logic        won_tgl_r;

  // only sda is ever driven, and only low
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = oe_r;

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= S_IDLE;  sh_r <= 8'h00;   cnt_r <= 4'h0;   byte_r <= 3'h0;
      rd_r <= 1'b0;    ara_r <= 1'b0;   cont_r <= 1'b0;  own_r <= 7'h00;
      ptr_r <= 8'h00;  hi_r <= 8'h00;   wdat_r <= 16'h0; txw_r <= 24'h0;
      txn_r <= 2'h0;   oe_r <= 1'b0;    hs_r <= 1'b0;
      wr_tgl_r <= 1'b0; rd_tgl_r <= 1'b0; won_tgl_r <= 1'b0;
    end else if (sp_cond) begin
      st_r <= S_IDLE;  oe_r <= 1'b0;  hs_r <= 1'b0;
    end else if (st_cond) begin
      st_r   <= S_RX;  oe_r <= 1'b0;  cnt_r <= 4'h0; byte_r <= 3'h0;
      rd_r   <= 1'b0;  ara_r <= 1'b0;
      own_r  <= {pm_i2c_pkg::ADDR_TOP, strap_s_r};
    end else begin
      unique case (st_r)
        S_IDLE: oe_r <= 1'b0;
        S_RX: begin
          if (rise) begin
            sh_r  <= {sh_r[6:0], sda_f};
            cnt_r <= cnt_r + 4'h1;
          end else if (fall && cnt_r == pm_i2c_pkg::ACK_SLOT) begin
            byte_r <= (byte_r == 3'h4) ? byte_r : byte_r + 3'h1;
            st_r   <= S_ACK;
            oe_r   <= 1'b1;
            unique case (byte_r)
              3'h0: begin
                if (sh_r[7:1] == own_r) begin
                  rd_r <= sh_r[0];
                  if (sh_r[0]) rd_tgl_r <= !rd_tgl_r;
                end else if (sh_r[7:1] == pm_i2c_pkg::ALERT_ADDR && sh_r[0]
                             && alert_sync_r[1]) begin
                  rd_r <= 1'b1;
                  ara_r <= 1'b1;
                end else begin
                  if (sh_r[7:3] == pm_i2c_pkg::HS_CODE_TOP) hs_r <= 1'b1;
                  st_r <= S_IDLE;
                  oe_r <= 1'b0;
                end
              end
              3'h1: ptr_r <= sh_r;
              3'h2: hi_r  <= sh_r;
              3'h3: begin
                wdat_r   <= {hi_r, sh_r};
                wr_tgl_r <= !wr_tgl_r;
              end
              default: begin
                st_r <= S_IDLE;
                oe_r <= 1'b0;
              end
            endcase
          end
        end
        // ack bit held for one scl low-high-low; read data arrives meanwhile
        S_ACK: if (fall) begin
          cnt_r <= 4'h0;
          if (rd_r) begin
            st_r  <= S_TX;
            txw_r <= ara_r ? {own_r, 1'b0, 16'h0000} : rd_cap_r;
            oe_r  <= ara_r ? !own_r[6] : !rd_cap_r[23];
            txn_r <= ara_r ? 2'h1 : (ptr_r == pm_i2c_pkg::REG_POWER_RESULT)
                     ? pm_i2c_pkg::POWER_BYTES : pm_i2c_pkg::WORD_BYTES;
          end else begin
            st_r <= S_RX;
            oe_r <= 1'b0;
          end
        end
        S_TX: begin
          if (rise) begin
            cnt_r <= cnt_r + 4'h1;
            if (ara_r && !oe_r && !sda_f) begin
              st_r <= S_IDLE;
            end
          end else if (fall) begin
            txw_r <= {txw_r[22:0], 1'b0};
            oe_r  <= (cnt_r == pm_i2c_pkg::ACK_SLOT) ? 1'b0 : !txw_r[22];
            if (cnt_r == pm_i2c_pkg::ACK_SLOT) begin
              st_r <= S_MACK;
              if (ara_r) won_tgl_r <= !won_tgl_r;
            end
          end
        end
        S_MACK: begin
          if (rise) begin
            cont_r <= !sda_f && (txn_r > 2'h1);
          end else if (fall) begin
            cnt_r <= 4'h0;
            if (cont_r) begin
              st_r  <= S_TX;
              txn_r <= txn_r - 2'h1;
              oe_r  <= !txw_r[23];
            end else begin
              st_r <= S_IDLE;
            end
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // clk domain: crossings in, register storage, read mux
  // ------------------------------------------------------------
  logic [2:0]  wr_sync_r;
  logic [2:0]  rd_sync_r;
  logic [2:0]  won_sync_r;
  logic [1:0]  hs_sync_r;
  logic [15:0] mem_r [0:pm_i2c_pkg::RW_DEPTH-1];
  logic [23:0] rd_nxt;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_sync_r  <= 3'h0;
      rd_sync_r  <= 3'h0;
      won_sync_r <= 3'h0;
      hs_sync_r  <= 2'h0;
    end else begin
      wr_sync_r  <= {wr_sync_r[1:0], wr_tgl_r};
      rd_sync_r  <= {rd_sync_r[1:0], rd_tgl_r};
      won_sync_r <= {won_sync_r[1:0], won_tgl_r};
      hs_sync_r  <= {hs_sync_r[0], hs_r};
    end
  end

  assign fast_plus_speed = hs_sync_r[1];

  // pointer and write word stay put for bytes after a toggle, so sampling is safe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < pm_i2c_pkg::RW_DEPTH; i++) mem_r[i] <= pm_i2c_pkg::rw_reset(5'(i));
      wr_stb       <= 1'b0;
      wr_ptr       <= 8'h00;
      wr_word      <= 16'h0000;
      alert_served <= 1'b0;
    end else begin
      wr_stb       <= wr_sync_r[2] != wr_sync_r[1];
      alert_served <= won_sync_r[2] != won_sync_r[1];
      if (wr_sync_r[2] != wr_sync_r[1]) begin
        wr_ptr  <= ptr_r;
        wr_word <= wdat_r;
        if (pm_i2c_pkg::rw_hit(ptr_r)) mem_r[ptr_r[4:0]] <= wdat_r;
      end
    end
  end

  // word left-aligned; sixteen-bit registers pad the low byte
  always_comb begin
    rd_nxt = 24'h0;
    if (pm_i2c_pkg::rw_hit(ptr_r)) rd_nxt = {mem_r[ptr_r[4:0]], 8'h00};
    unique case (ptr_r)
      pm_i2c_pkg::REG_SHUNT_RESULT:   rd_nxt = {shunt_voltage_result, 8'h00};
      pm_i2c_pkg::REG_BUS_RESULT:     rd_nxt = {bus_voltage_result, 8'h00};
      pm_i2c_pkg::REG_TEMP_RESULT:    rd_nxt = {die_temperature_result, 8'h00};
      pm_i2c_pkg::REG_CURRENT_RESULT: rd_nxt = {current_result, 8'h00};
      pm_i2c_pkg::REG_POWER_RESULT:   rd_nxt = power_result;
      pm_i2c_pkg::REG_DIAG_FLAGS:     rd_nxt = {diagnostic_flags, 8'h00};
      pm_i2c_pkg::REG_MAKER_CODE:     rd_nxt = {MAKER_CODE, 8'h00};
      default: ;
    endcase
  end

  // read request answered by a toggle back; hold word is read in the link domain
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_hold_r    <= 24'h0;
      rd_ack_tgl_r <= 1'b0;
    end else if (rd_sync_r[2] != rd_sync_r[1]) begin
      rd_hold_r    <= rd_nxt;
      rd_ack_tgl_r <= !rd_ack_tgl_r;
    end
  end

endmodule // pm_i2c_target

// >>> test_power_monitor_i2c_target_port.sv
// bench: controller and target ends face each other over the bus
// assumes package, interface, both ends and the checker compiled first
`timescale 1ns/10ps
module test_power_monitor_i2c_target_port;
  localparam logic [15:0] MAKER = 16'h3C3C;  // arbitrary value
  logic        clk = 1'b0, link_clk = 1'b0, nrst = 1'b0, alert_pending = 1'b0;
  logic        cmd_valid = 1'b0, cmd_read = 1'b0, cmd_hs = 1'b0, cmd_stop = 1'b0;
  logic        cmd_ready, done, nack, hs_active, wr_stb, alert_served, fast_plus_speed;
  logic [6:0]  cmd_addr = 7'h00;
  logic [1:0]  cmd_nbytes = 2'h0, sh, sl;
  logic [23:0] cmd_wdata = 24'h0, rdata, pwr;
  logic [15:0] word, res, wr_word;
  logic [7:0]  wr_ptr;
  int          seed = 94075, mismatches = 0, checks_done = 0, stb_cnt = 0, srv_cnt = 0;
  pm_i2c_if bus_if ();
  // scl quarter long enough for the link-side sync and filter
  pm_i2c_controller #(.FS_QTR(48), .HS_QTR(32)) pm_i2c_controller_i (
    .clk(clk), .nrst(nrst), .bus(bus_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_read(cmd_read), .cmd_hs(cmd_hs), .cmd_stop(cmd_stop), .cmd_addr(cmd_addr),
    .cmd_nbytes(cmd_nbytes), .cmd_wdata(cmd_wdata), .done(done), .nack(nack),
    .rdata(rdata), .hs_active(hs_active));
  pm_i2c_target #(.MAKER_CODE(MAKER)) pm_i2c_target_i (
    .clk(clk), .link_clk(link_clk), .nrst(nrst), .bus(bus_if), .addr_strap_high(sh),
    .addr_strap_low(sl), .shunt_voltage_result(res), .bus_voltage_result(~res),
    .die_temperature_result(res ^ 16'h00FF), .current_result(res + 16'h0001),
    .power_result(pwr), .diagnostic_flags(res), .alert_pending(alert_pending),
    .wr_stb(wr_stb), .wr_ptr(wr_ptr), .wr_word(wr_word), .alert_served(alert_served),
    .fast_plus_speed(fast_plus_speed));
  pm_i2c_checker pm_i2c_checker_i (.clk(clk), .nrst(nrst),
    .ctrl_scl_oe(bus_if.ctrl_scl_oe), .dev_sda_o(bus_if.dev_sda_o),
    .dev_sda_oe(bus_if.dev_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));
  // clocks with unrelated phase
  always #2 clk = ~clk;
  initial #5.3 forever #16 link_clk = ~link_clk;
  // pulse counters, since both strobes last one cycle only
  always @(posedge clk) begin
    if (wr_stb === 1'b1) stb_cnt++;
    if (alert_served === 1'b1) srv_cnt++;
  end
  function automatic logic [6:0] own_of(input logic [1:0] h, input logic [1:0] l);
    return {3'h4, h, l};
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one command, held until taken, then bounded wait for done
  task automatic xfer(input logic rd, input logic hs, input logic stp, input logic [6:0] a,
                      input logic [1:0] n, input logic [23:0] wd);
    int k;
    k = 0;
    @(negedge clk);
    {cmd_valid, cmd_read, cmd_hs, cmd_stop, cmd_addr, cmd_nbytes, cmd_wdata} =
      {1'b1, rd, hs, stp, a, n, wd};
    while (cmd_ready !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 20000) mismatches++;
  endtask
  task automatic rd_reg(input logic [7:0] p, input logic [1:0] n);
    xfer(1'b0, 1'b0, 1'b0, own_of(sh, sl), 2'h1, {p, 16'h0000});
    xfer(1'b1, 1'b0, 1'b1, own_of(sh, sl), n, 24'h0);
  endtask
  // speed flag crosses domains: bounded wait, then compare
  task automatic settle(input logic v);
    int k;
    for (k = 0; k < 400 && fast_plus_speed !== v; k++) @(negedge clk);
    chk({23'h0, fast_plus_speed}, {23'h0, v});
  endtask
  task automatic wrap_up();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
  initial begin
    {sh, sl} = 4'($random(seed));
    pwr = 24'($random(seed));
    res = 16'($random(seed));
    word = 16'($random(seed));
    repeat (5) @(negedge link_clk);
    nrst = 1'b1;
    repeat (5) @(negedge link_clk);
    rd_reg(pm_i2c_pkg::REG_CONV_SETUP, 2'h2);
    chk(rdata, 24'h00FB68);
    xfer(1'b1, 1'b0, 1'b1, own_of(sh, sl), 2'h2, 24'h0);
    chk(rdata, 24'h00FB68);
    xfer(1'b0, 1'b0, 1'b1, own_of(sh, sl), 2'h3, {pm_i2c_pkg::REG_SHUNT_OVER, word});
    chk({wr_ptr, wr_word}, {pm_i2c_pkg::REG_SHUNT_OVER, word});
    chk(24'(stb_cnt), 24'h1);
    rd_reg(pm_i2c_pkg::REG_SHUNT_OVER, 2'h2);
    chk(rdata, {8'h00, word});
    {sh, sl} = 4'($random(seed));  // straps renewed with the bus idle
    rd_reg(pm_i2c_pkg::REG_POWER_RESULT, 2'h3);
    chk(rdata, pwr);
    xfer(1'b0, 1'b1, 1'b0, 7'h00, 2'h0, 24'h0);
    settle(1'b1);
    chk({23'h0, hs_active}, 24'h1);
    xfer(1'b1, 1'b0, 1'b1, own_of(sh, sl), 2'h3, 24'h0);
    chk(rdata, pwr);
    settle(1'b0);
    chk({23'h0, hs_active}, 24'h0);
    rd_reg(pm_i2c_pkg::REG_MAKER_CODE, 2'h2);
    chk(rdata, {8'h00, MAKER});
    xfer(1'b0, 1'b0, 1'b1, own_of(sh, sl) ^ 7'h10, 2'h1, 24'h0);
    chk({23'h0, nack}, 24'h1);
    alert_pending = 1'b1;
    xfer(1'b1, 1'b0, 1'b1, 7'h0C, 2'h1, 24'h0);
    chk(rdata, {16'h0000, own_of(sh, sl), 1'b0});
    chk(24'(srv_cnt), 24'h1);
    wrap_up();
  end
endmodule  // test_power_monitor_i2c_target_port
